// File: oled_cmd_consts.vh
`ifndef OLED_CMD_CONSTS_VH
`define OLED_CMD_CONSTS_VH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define CLOCK_MHZ          40
`define BUSY_TIME_NS       2000
`define BUSY_CYCLES        ((`BUSY_TIME_NS * `CLOCK_MHZ + 999) / 1000)

// ----------------------------------------
// Display RAM geometry
// ----------------------------------------
`define RAM_COLUMNS        132
`define RAM_PAGES          8
`define RAM_WORDS          1056
`define LAST_COLUMN        8'h83

// ----------------------------------------
// Command codes
// ----------------------------------------
`define CMD_CONTRAST       8'h81
`define CMD_DCDC           8'hAD
`define CMD_MUX_RATIO      8'hA8
`define CMD_OFFSET         8'hD3
`define CMD_CLOCK          8'hD5
`define CMD_CHARGE         8'hD9
`define CMD_PADS           8'hDA
`define CMD_DESELECT       8'hDB
`define CMD_RMW_START      8'hE0
`define CMD_RMW_END        8'hEE
`define CMD_NOP            8'hE3
`define CMD_DISPLAY_OFF    8'hAE
`define CMD_DISPLAY_ON     8'hAF

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PAD_MODE_BIT       4
`define DCDC_BIT           0
`define SCAN_DIR_BIT       3
`define STATUS_BUSY_BIT    7
`define STATUS_OFF_BIT     6

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_COLUMN         8'h00
`define RST_START_LINE     6'h00
`define RST_CONTRAST       8'h80
`define RST_MUX_RATIO      6'h3F
`define RST_OFFSET         6'h00
`define RST_CLOCK          8'h50
`define RST_CHARGE         8'h22
`define RST_DESELECT       8'h35
`define RST_PAGE           3'h0

// ----------------------------------------
// Deselect factor, millionths
// ----------------------------------------
`define DESEL_BASE         430000
`define DESEL_STEP         6415
`define DESEL_SAT_CODE     8'h40
`define DESEL_ONE          20'hF4240

`endif

// File: oled_cmd_decoder.v
// How it works
// - DBH then any byte sets deselect level
// - Factor 0.430 plus code step, saturates
// - In edit mode only writes advance column
// - End command restores saved column address
// - Data write stores byte, column plus one
// - Status D7 busy; commands rejected while busy
// - Status D6 high means display off
// - First read after addressing is a dummy
// - Data read returns byte, consecutive reads
// - No RAM readback in serial mode
// - 0x/1x commands load column nibbles
// - 01xxxxxx loads display start line
// - 81H plus byte sets contrast
// - Remap, entire-on and inverse select commands
// - A8H plus byte sets multiplex ratio
// - AEH/AFH panel off/on, off at reset
// - B0H-B7H load page address
// - C0H-C8H bit 3 sets scan direction
// - D3H plus byte sets display offset
// - D5H plus byte sets clock setting
// - D9H charge periods, DAH pad layout
`timescale 1ns/1ps
`include "oled_cmd_consts.vh"

module oled_cmd_decoder (
    input  wire        clock,
    input  wire        rst_n,
    input  wire        cs_n,
    input  wire        cmd_data_select,
    input  wire        rd_n,
    input  wire        wr_n,
    input  wire [7:0]  data_in,
    input  wire        serial_mode,
    output reg  [7:0]  data_out,
    output reg         data_oe_n,
    output reg         busy,
    output reg  [7:0]  column,
    output reg  [2:0]  page,
    output reg  [5:0]  start_line,
    output reg  [7:0]  contrast,
    output reg         seg_remap,
    output reg         entire_on,
    output reg         inverse,
    output reg  [5:0]  mux_ratio,
    output reg         display_on,
    output reg         com_reverse,
    output reg  [5:0]  display_offset,
    output reg  [7:0]  clock_setting,
    output reg  [7:0]  charge_periods,
    output reg         pad_alternative,
    output reg  [7:0]  deselect_code,
    output reg  [19:0] deselect_factor,
    output reg         dcdc_on,
    output reg         rmw_active
);

    localparam ST_COMMAND = 1'b0;
    localparam ST_PARAM   = 1'b1;
    localparam [31:0] BUSY_LOAD = `BUSY_CYCLES;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function [10:0] ram_index;
        input [2:0] p;
        input [7:0] c;
        begin
            ram_index = {8'h00, p} * 11'd132 + {3'b000, c};
        end
    endfunction

    function [7:0] next_column_of;
        input [7:0] c;
        begin
            if (c >= `LAST_COLUMN) begin
                next_column_of = 8'h00;
            end else begin
                next_column_of = c + 8'h01;
            end
        end
    endfunction

    function [19:0] desel_of;
        input [7:0] code;
        integer     v;
        begin
            v = `DESEL_BASE + code * `DESEL_STEP;
            if (code >= `DESEL_SAT_CODE) begin
                desel_of = `DESEL_ONE;
            end else begin
                desel_of = v[19:0];
            end
        end
    endfunction

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    reg  [11:0] pins_s1;
    reg  [11:0] pins_s2;
    reg         wr_prev;
    reg         rd_prev;
    reg         wr_cs;
    reg         wr_sel;
    reg  [7:0]  wr_byte;

    wire        cs_s    = pins_s2[11];
    wire        sel_s   = pins_s2[10];
    wire        rd_s    = pins_s2[9];
    wire        wr_s    = pins_s2[8];
    wire [7:0]  din_s   = pins_s2[7:0];
    reg         serial_s1;
    reg         serial_s2;

    wire        wr_done = ~wr_prev & wr_s & ~wr_cs;
    wire        rd_start = rd_prev & ~rd_s & ~cs_s;
    wire        rd_end  = ~rd_prev & rd_s;

    always @(posedge clock) begin
        pins_s1   <= {cs_n, cmd_data_select, rd_n, wr_n, data_in};
        pins_s2   <= pins_s1;
        serial_s1 <= serial_mode;
        serial_s2 <= serial_s1;
        if (!rst_n) begin
            wr_prev <= 1'b1;
            rd_prev <= 1'b1;
            wr_cs   <= 1'b1;
            wr_sel  <= 1'b0;
            wr_byte <= 8'h00;
        end else begin
            wr_prev <= wr_s;
            rd_prev <= rd_s;
            // Data is only promised near the strobe's end, so keep the last low sample
            if (!wr_s) begin
                wr_cs   <= cs_s;
                wr_sel  <= sel_s;
                wr_byte <= din_s;
            end
        end
    end

    // ----------------------------------------
    // Reset busy timer
    // ----------------------------------------
    reg  [7:0]  busy_count;
    wire        boot_busy = (busy_count != 8'h00);

    always @(posedge clock) begin
        if (!rst_n) begin
            busy_count <= BUSY_LOAD[7:0];
        end else if (boot_busy) begin
            busy_count <= busy_count - 8'h01;
        end
    end

    // ----------------------------------------
    // Two-entry write buffer
    // ----------------------------------------
    reg  [8:0]  fifo_mem [0:1];
    reg         fifo_wptr;
    reg         fifo_rptr;
    reg  [1:0]  fifo_count;

    wire        data_rd   = rd_start & sel_s & ~serial_s2;
    // Writes seen while the reset timer runs are refused, not queued
    wire        in_valid  = wr_done & ~boot_busy;
    wire        in_ready  = (fifo_count != 2'd2);
    wire        out_valid = (fifo_count != 2'd0);
    // Decoder waits a cycle on a RAM read so no popped word is skipped
    wire        out_ready = ~data_rd;
    wire        push      = in_valid & in_ready;
    wire        pop       = out_valid & out_ready;
    wire [8:0]  out_word  = fifo_mem[fifo_rptr];

    always @(posedge clock) begin
        if (!rst_n) begin
            fifo_wptr  <= 1'b0;
            fifo_rptr  <= 1'b0;
            fifo_count <= 2'd0;
        end else begin
            if (push) begin
                fifo_mem[fifo_wptr] <= {wr_sel, wr_byte};
                fifo_wptr           <= ~fifo_wptr;
            end
            if (pop) begin
                fifo_rptr <= ~fifo_rptr;
            end
            fifo_count <= fifo_count + {1'b0, push} - {1'b0, pop};
        end
    end

    // ----------------------------------------
    // Display RAM
    // ----------------------------------------
    reg  [7:0]  ram [0:`RAM_WORDS-1];
    reg  [7:0]  read_latch;
    reg  [7:0]  saved_column;
    reg         state;
    reg  [7:0]  pending_cmd;

    wire        is_data  = out_word[8];
    wire [7:0]  word     = out_word[7:0];
    wire        ram_ok   = (column <= `LAST_COLUMN);

    always @(posedge clock) begin
        if (pop && is_data && ram_ok) begin
            ram[ram_index(page, column)] <= word;
        end
        if (data_rd) begin
            // Latch refilled after answering: first read after addressing is stale
            read_latch <= ram_ok ? ram[ram_index(page, column)] : 8'h00;
        end
    end

    // ----------------------------------------
    // Host read port
    // ----------------------------------------
    always @(posedge clock) begin
        if (!rst_n) begin
            data_out  <= 8'h00;
            data_oe_n <= 1'b1;
            busy      <= 1'b1;
        end else begin
            busy <= boot_busy | ~in_ready;
            if (rd_start) begin
                data_oe_n <= 1'b0;
                if (!sel_s) begin
                    data_out <= {boot_busy | ~in_ready, ~display_on, 6'h00};
                end else if (serial_s2) begin
                    data_out <= 8'h00;
                end else begin
                    data_out <= read_latch;
                end
            end else if (rd_end) begin
                data_oe_n <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Command decoder
    // ----------------------------------------
    always @(posedge clock) begin
        if (!rst_n) begin
            state           <= ST_COMMAND;
            pending_cmd     <= 8'h00;
            column          <= `RST_COLUMN;
            page            <= `RST_PAGE;
            start_line      <= `RST_START_LINE;
            contrast        <= `RST_CONTRAST;
            seg_remap       <= 1'b0;
            entire_on       <= 1'b0;
            inverse         <= 1'b0;
            mux_ratio       <= `RST_MUX_RATIO;
            display_on      <= 1'b0;
            com_reverse     <= 1'b0;
            display_offset  <= `RST_OFFSET;
            clock_setting   <= `RST_CLOCK;
            charge_periods  <= `RST_CHARGE;
            pad_alternative <= 1'b1;
            deselect_code   <= `RST_DESELECT;
            dcdc_on         <= 1'b0;
            rmw_active      <= 1'b0;
            saved_column    <= `RST_COLUMN;
        end else begin
            // A pop never meets a RAM read, so one column move per cycle
            if (pop && is_data) begin
                column <= next_column_of(column);
            end else if (data_rd && !rmw_active) begin
                column <= next_column_of(column);
            end else if (pop && state == ST_PARAM) begin
                state <= ST_COMMAND;
                case (pending_cmd)
                    `CMD_CONTRAST:  contrast       <= word;
                    `CMD_MUX_RATIO: mux_ratio      <= word[5:0];
                    `CMD_OFFSET:    display_offset <= word[5:0];
                    `CMD_CLOCK:     clock_setting  <= word;
                    `CMD_CHARGE:    charge_periods <= word;
                    `CMD_PADS:      pad_alternative <= word[`PAD_MODE_BIT];
                    `CMD_DESELECT:  deselect_code  <= word;
                    `CMD_DCDC:      dcdc_on        <= word[`DCDC_BIT];
                    default:        pending_cmd    <= 8'h00;
                endcase
            end else if (pop) begin
                case (word[7:4])
                    4'h0: column <= {column[7:4], word[3:0]};
                    4'h1: column <= {word[3:0], column[3:0]};
                    4'h4, 4'h5, 4'h6, 4'h7: start_line <= word[5:0];
                    4'hB: begin
                        if (!word[3]) begin
                            page <= word[2:0];
                        end
                    end
                    4'hC: com_reverse <= word[`SCAN_DIR_BIT];
                    default: begin
                        case (word)
                            `CMD_CONTRAST, `CMD_MUX_RATIO, `CMD_OFFSET, `CMD_CLOCK,
                            `CMD_CHARGE, `CMD_PADS, `CMD_DESELECT, `CMD_DCDC: begin
                                state       <= ST_PARAM;
                                pending_cmd <= word;
                            end
                            8'hA0, 8'hA1: seg_remap <= word[0];
                            8'hA4, 8'hA5: entire_on <= word[0];
                            8'hA6, 8'hA7: inverse   <= word[0];
                            `CMD_DISPLAY_OFF, `CMD_DISPLAY_ON:
                                display_on <= word[0];
                            `CMD_RMW_START: begin
                                rmw_active   <= 1'b1;
                                saved_column <= column;
                            end
                            `CMD_RMW_END: begin
                                if (rmw_active) begin
                                    column <= saved_column;
                                end
                                rmw_active <= 1'b0;
                            end
                            // Unlisted codes ignored like a no-op
                            default: state <= ST_COMMAND;
                        endcase
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // Deselect factor
    // ----------------------------------------
    always @(posedge clock) begin
        if (!rst_n) begin
            deselect_factor <= desel_of(`RST_DESELECT);
        end else begin
            deselect_factor <= desel_of(deselect_code);
        end
    end

endmodule // oled_cmd_decoder

// File: oled_cmd_decoder_checker.sv
`timescale 1ns/1ps
module oled_cmd_decoder_checker (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        cmd_data_select,
    input wire logic        rd_n,
    input wire logic [7:0]  data_out,
    input wire logic        data_oe_n,
    input wire logic        busy,
    input wire logic        display_on,
    input wire logic [7:0]  column,
    input wire logic        rmw_active,
    input wire logic [7:0]  deselect_code,
    input wire logic [19:0] deselect_factor
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    // Column as it stood before the edit mode began
    logic [7:0] saved_column;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            saved_column <= 8'h00;
        end else if (!rmw_active) begin
            saved_column <= column;
        end
    end

    // ----------------------------------------
    // Sequences
    // ----------------------------------------
    sequence status_answer;
        $fell(data_oe_n) && !cmd_data_select;
    endsequence
    sequence read_released;
        $rose(rd_n);
    endsequence

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    chk_status_bits: assert property (status_answer |-> data_out[6] == !$past(display_on) && data_out[2:0] == 3'h0)
        else $error("status byte does not match display state");
    chk_busy_after_reset: assert property ($rose(rst_n) |-> (busy && !display_on) [*8])
        else $error("busy or display state wrong after reset");
    chk_factor_linear: assert property ($stable(deselect_code) && deselect_code < 8'h40 |-> deselect_factor == 20'h68FB0 + 20'h0190F * deselect_code)
        else $error("deselect factor off the linear law");
    chk_factor_saturate: assert property ($stable(deselect_code) && deselect_code >= 8'h40 |-> deselect_factor == 20'hF4240)
        else $error("deselect factor not saturated");
    chk_read_release: assert property (read_released |-> ##[1:4] data_oe_n)
        else $error("bus still driven after read strobe ended");
    chk_drive_on_read: assert property ($fell(data_oe_n) |-> !rd_n)
        else $error("bus driven without a read strobe");
    chk_rmw_read_hold: assert property (rmw_active && !rd_n && cmd_data_select |=> $stable(column) || !rmw_active)
        else $error("column moved on a read in edit mode");
    chk_rmw_restore: assert property ($fell(rmw_active) |-> ##[0:1] column == saved_column)
        else $error("column not restored at end of edit mode");
endmodule // oled_cmd_decoder_checker

// File: oled_host_model.sv
`timescale 1ns/1ps
module oled_host_model (
    input  wire logic       clock,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe_n,
    output logic            cs_n = 1'b1,
    output logic            cmd_data_select = 1'b0,
    output logic            rd_n = 1'b1,
    output logic            wr_n = 1'b1,
    output logic [7:0]      data_in = 8'h00
);
    // Callers send listed codes only
    task automatic write_byte(input logic sel, input logic [7:0] value);
        @(posedge clock);
        cs_n <= 1'b0;
        cmd_data_select <= sel;
        data_in <= value;
        wr_n <= 1'b0;
        repeat (4) @(posedge clock);
        wr_n <= 1'b1;
        // Held past the strobe: the device samples through a synchroniser
        repeat (3) @(posedge clock);
        cs_n <= 1'b1;
        data_in <= ~value;
        repeat (8) @(posedge clock);
    endtask

    task automatic read_byte(input logic sel, output logic [7:0] value, output logic ok);
        int n;
        ok = 1'b0;
        value = 8'h00;
        @(posedge clock);
        cs_n <= 1'b0;
        cmd_data_select <= sel;
        rd_n <= 1'b0;
        for (n = 0; n < 12 && !ok; n++) begin
            @(posedge clock);
            if (data_oe_n === 1'b0) begin
                ok = 1'b1;
                value = data_out;
            end
        end
        rd_n <= 1'b1;
        repeat (3) @(posedge clock);
        cs_n <= 1'b1;
        repeat (4) @(posedge clock);
    endtask
endmodule // oled_host_model

// File: oled_cmd_decoder_tb_top.sv
`timescale 1ns/1ps
module oled_cmd_decoder_tb_top;
    logic        clock;
    logic        rst_n;
    logic        serial_mode;
    wire         cs_n, cmd_data_select, rd_n, wr_n, data_oe_n, busy, rmw_active;
    wire         seg_remap, entire_on, inverse, display_on, com_reverse, pad_alternative, dcdc_on;
    wire  [7:0]  data_in, data_out, column, contrast, clock_setting, charge_periods;
    wire  [7:0]  deselect_code;
    wire  [2:0]  page;
    wire  [5:0]  start_line, mux_ratio, display_offset;
    wire  [19:0] deselect_factor;
    int          num_errors;
    int          total_checks;
    wire  [66:0] settings = {column, page, start_line, display_offset, display_on,
                             pad_alternative, contrast, mux_ratio, clock_setting, charge_periods,
                             deselect_code, seg_remap, entire_on, inverse, com_reverse};
    logic [7:0]  seq [23] = '{8'hAF, 8'h81, 8'hAE, 8'hA8, 8'h0F, 8'hD3, 8'h2A, 8'hD5, 8'hF1,
                              8'hD9, 8'hA5, 8'hDA, 8'h02, 8'hDB, 8'h81, 8'h5C, 8'hA1, 8'hA5,
                              8'hA7, 8'hC8, 8'hB5, 8'h13, 8'h04};
    logic [7:0]  undo [4] = '{8'hA0, 8'hA4, 8'hA6, 8'hC0};

    oled_cmd_decoder u_oled_cmd_decoder (
        .clock, .rst_n, .cs_n, .cmd_data_select, .rd_n, .wr_n, .data_in, .serial_mode,
        .data_out, .data_oe_n, .busy, .column, .page, .start_line, .contrast, .seg_remap,
        .entire_on, .inverse, .mux_ratio, .display_on, .com_reverse, .display_offset,
        .clock_setting, .charge_periods, .pad_alternative, .deselect_code,
        .deselect_factor, .dcdc_on, .rmw_active
    );
    oled_host_model u_oled_host_model (
        .clock, .data_out, .data_oe_n, .cs_n, .cmd_data_select, .rd_n, .wr_n, .data_in
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic report_and_stop;
        if (num_errors == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input logic [79:0] got, input logic [79:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] b);
        u_oled_host_model.write_byte(1'b0, b);
    endtask
    task automatic wdat(input logic [7:0] b);
        u_oled_host_model.write_byte(1'b1, b);
    endtask
    task automatic set_column(input logic [7:0] c);
        cmd({4'h1, c[7:4]});
        cmd({4'h0, c[3:0]});
    endtask
    task automatic rd(input logic sel, input logic [7:0] mask, input logic [7:0] exp);
        logic [7:0] v;
        logic       ok;
        u_oled_host_model.read_byte(sel, v, ok);
        if (!ok) begin
            num_errors++;
            $display("unexpected at %0t: got %0h expected %0h", $time, ok, 1'b1);
            report_and_stop();
        end
        check(v & mask, exp);
    endtask

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        int n;
        rst_n = 1'b0;
        serial_mode = 1'b0;
        num_errors = 0;
        total_checks = 0;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        rd(1'b0, 8'hC7, 8'hC0);
        cmd(8'hAF);
        for (n = 0; n < 200 && busy !== 1'b0; n++) @(posedge clock);
        if (busy !== 1'b0) begin
            num_errors++;
            $display("unexpected at %0t: got %0h expected %0h", $time, busy, 1'b0);
            report_and_stop();
        end
        check({dcdc_on, deselect_factor}, {1'b0, 20'hBBFCB});
        check(settings, {8'h00, 3'h0, 6'h00, 6'h00, 1'b0, 1'b1, 8'h80, 6'h3F, 8'h50, 8'h22, 8'h35, 4'h0});
        foreach (seq[i]) cmd(seq[i]);
        check(settings, {8'h34, 3'h5, 6'h1C, 6'h2A, 1'b1, 1'b0, 8'hAE, 6'h0F, 8'hF1, 8'hA5, 8'h81, 4'hF});
        cmd(8'hE3);
        check(settings, {8'h34, 3'h5, 6'h1C, 6'h2A, 1'b1, 1'b0, 8'hAE, 6'h0F, 8'hF1, 8'hA5, 8'h81, 4'hF});
        check(deselect_factor, 20'hF4240);
        cmd(8'hAD);
        cmd(8'h8B);
        check(dcdc_on, 1'b1);
        rd(1'b0, 8'hC7, 8'h00);
        foreach (undo[i]) cmd(undo[i]);
        check(settings[3:0], 4'h0);
        set_column(8'h34);
        wdat(8'h3C);
        wdat(8'h5A);
        check(column, 8'h36);
        set_column(8'h34);
        rd(1'b1, 8'h00, 8'h00);
        check(column, 8'h35);
        rd(1'b1, 8'hFF, 8'h3C);
        rd(1'b1, 8'hFF, 8'h5A);
        set_column(8'h34);
        cmd(8'hE0);
        rd(1'b1, 8'h00, 8'h00);
        rd(1'b1, 8'hFF, 8'h3C);
        check(column, 8'h34);
        wdat(8'h77);
        check({rmw_active, column}, {1'b1, 8'h35});
        cmd(8'hEE);
        check({rmw_active, column}, {1'b0, 8'h34});
        set_column(8'h34);
        rd(1'b1, 8'h00, 8'h00);
        rd(1'b1, 8'hFF, 8'h77);
        set_column(8'h83);
        wdat(8'h11);
        check(column, 8'h00);
        set_column(8'h34);
        @(posedge clock) serial_mode <= 1'b1;
        rd(1'b1, 8'hFF, 8'h00);
        check(column, 8'h34);
        @(posedge clock) serial_mode <= 1'b0;
        report_and_stop();
    end
endmodule // oled_cmd_decoder_tb_top

bind oled_cmd_decoder oled_cmd_decoder_checker u_oled_cmd_decoder_checker (
    .clock(clock), .rst_n(rst_n), .cmd_data_select(cmd_data_select), .rd_n(rd_n),
    .data_out(data_out), .data_oe_n(data_oe_n), .busy(busy), .display_on(display_on),
    .column(column), .rmw_active(rmw_active), .deselect_code(deselect_code),
    .deselect_factor(deselect_factor)
);
